// [src/vrm_consts.vh]
// Constants for the vector relocation and processor mode status block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef VRM_CONSTS_VH
`define VRM_CONSTS_VH

// Register offsets on the plain register port.
`define VRM_ADDR_W 8
`define VRM_OFS_PROCESSOR_MODE_STATUS 8'h00
`define VRM_OFS_STATUS 8'h01

// Field positions in the processor mode status register.
`define VRM_PTR_HI 15
`define VRM_PTR_LO 7
`define VRM_BIT_ROM 6
`define VRM_BIT_RAM_OVERLAY 5
`define VRM_BIT_ADDRESS_VISIBILITY 4
`define VRM_BIT_UMAP 3
`define VRM_BIT_CKOFF 2
`define VRM_BIT_SATURATE_MULTIPLY 1
`define VRM_BIT_SST 0

// Reset values.
`define VRM_PTR_RST 9'h1ff
`define VRM_LOW_RST 6'h00

// Vector address layout.
`define VRM_VEC_RESET 5'h00

// Memory map boundaries.
`define VRM_PAGE0_TOP 16'h007f
`define VRM_LOWRAM_TOP 16'h7fff
`define VRM_ROM_BASE 16'hc000

// Saturation limits.
`define VRM_FRAC_OVF 32'h40000000
`define VRM_MUL_MAX 32'h7fffffff
`define VRM_ST_MAX 16'h7fff
`define VRM_ST_MIN 16'h8000

// Clock output divider default.
`define VRM_CLK_DIV 4

`endif

// [src/vrm_clkdiv.v]
// One-cycle enable pulse every DIV clocks for the clock output pin.
// Assumes a single clock and a synchronous active-high reset.
module vrm_clkdiv #(
    parameter DIV = 4,
    parameter CW = 8
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Enable pulse
    output reg tick_o
);
    reg [CW-1:0] cnt_q;

    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= {CW{1'b0}};
            tick_o <= 1'b0;
        end else if (cnt_q == DIV[CW-1:0] - 1'b1) begin
            cnt_q <= {CW{1'b0}};
            tick_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule // vrm_clkdiv

// [src/vrm_map.v]
// Combinational decode of program and data addresses to on-chip memories.
// Assumes the mode bits come from the mode status register of the top.
`include "vrm_consts.vh"
module vrm_map (
    // Mode bits
    input wire rom_disable_mode_i,
    input wire ram_overlay_i,
    input wire upper_ram_data_map_i,
    // Addresses
    input wire [15:0] prog_addr_i,
    input wire [15:0] data_addr_i,
    // Selects
    output reg prog_rom_sel_o,
    output reg prog_ram_sel_o,
    output reg data_ram_sel_o,
    output reg [2:0] data_ram_blk_o,
    output reg prog_ext_o
);
    always @* begin
        prog_rom_sel_o = 1'b0;
        prog_ram_sel_o = 1'b0;
        data_ram_sel_o = 1'b0;
        data_ram_blk_o = data_addr_i[15:13];
        // On-chip ROM only while the disable bit is clear.
        if (!rom_disable_mode_i && prog_addr_i >= `VRM_ROM_BASE) begin
            prog_rom_sel_o = 1'b1;
        end
        // Overlay puts the lower blocks in program space, page 0 excluded.
        if (ram_overlay_i && prog_addr_i > `VRM_PAGE0_TOP &&
                prog_addr_i <= `VRM_LOWRAM_TOP) begin
            prog_ram_sel_o = 1'b1;
        end
        // Lower blocks always live in data space above page 0.
        if (data_addr_i > `VRM_PAGE0_TOP &&
                data_addr_i <= `VRM_LOWRAM_TOP) begin
            data_ram_sel_o = 1'b1;
        end
        // Upper blocks, one per 8K range, only when mapped.
        if (upper_ram_data_map_i && data_addr_i > `VRM_LOWRAM_TOP) begin
            data_ram_sel_o = 1'b1;
        end
        prog_ext_o = !prog_rom_sel_o && !prog_ram_sel_o;
    end
endmodule // vrm_map

// [src/vrm_top.v]
// Processor mode status register with vector table relocation logic.
// Assumes a single 100 MHz clock, synchronous active-high reset, and a
// plain register port whose read data appears one cycle after the strobe.
//
// Implementation choices: the strobed register port and the address map.
`include "vrm_consts.vh"
module vrm_top #(
    parameter CLK_DIV = `VRM_CLK_DIV
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Register port
    input wire [`VRM_ADDR_W-1:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_we_i,
    input wire reg_re_i,
    output reg [15:0] reg_rdata_o,
    // Mode pin and core controls
    input wire rom_disable_mode_pin_i,
    input wire soft_reset_i,
    input wire overflow_mode_i,
    input wire fractional_mode_i,
    // Vector fetch request
    input wire vec_req_i,
    input wire [4:0] vec_num_i,
    output reg vec_load_o,
    output reg [15:0] vec_addr_o,
    // Address visibility
    input wire [15:0] prog_addr_i,
    input wire ext_access_i,
    input wire [15:0] ext_addr_i,
    output reg [15:0] ext_addr_o,
    // Memory selects
    input wire [15:0] data_addr_i,
    output reg prog_rom_sel_o,
    output reg prog_ram_sel_o,
    output reg data_ram_sel_o,
    output reg [2:0] data_ram_blk_o,
    // Clock output pin
    output reg clock_output_pin_o,
    // Saturation datapath
    input wire [31:0] mul_prod_i,
    output reg [31:0] mul_prod_o,
    input wire [39:0] store_shifted_i,
    output reg [15:0] store_data_o,
    // Mode outputs
    output reg [15:0] processor_mode_status_o
);
    // Mode status register fields.
    reg [8:0] vector_page_pointer_q;
    reg rom_disable_mode_q;
    reg ram_overlay_q;
    reg address_visibility_q;
    reg upper_ram_data_map_q;
    reg clock_output_off_q;
    reg saturate_multiply_q;
    reg saturate_store_q;
    wire [15:0] processor_mode_status_w;

    // Pin synchroniser and reset-release detector.
    reg pin_s1_q;
    reg pin_s2_q;
    reg rst_q;
    wire rst_release_w;

    // Decoder and divider wires.
    wire rom_sel_w;
    wire ram_sel_w;
    wire dram_sel_w;
    wire [2:0] dram_blk_w;
    wire prog_ext_w;
    wire clk_tick_w;
    reg clk_phase_q;

    // Saturation helpers.
    wire sat_mul_en_w;
    wire st_pos_ovf_w;
    wire st_neg_ovf_w;

    // Register port decode, the live status word and the fixed reset word.
    wire processor_mode_status_we_w;
    wire [15:0] status_w;
    wire [15:0] processor_mode_status_rst_w;

    // Vector addresses for the reset and for user vectors.
    wire [15:0] vec_reset_w;
    wire [15:0] vec_user_w;

    assign processor_mode_status_w = {vector_page_pointer_q, rom_disable_mode_q,
        ram_overlay_q, address_visibility_q, upper_ram_data_map_q,
        clock_output_off_q, saturate_multiply_q, saturate_store_q};
    assign rst_release_w = rst_q && !rst_i;
    assign processor_mode_status_we_w = reg_we_i && (reg_addr_i == `VRM_OFS_PROCESSOR_MODE_STATUS);
    assign status_w = {11'h000, prog_ext_w, dram_blk_w, clk_phase_q};
    assign processor_mode_status_rst_w = {`VRM_PTR_RST, 1'b0, `VRM_LOW_RST};
    assign vec_reset_w = {`VRM_PTR_RST, `VRM_VEC_RESET, 2'b00};
    assign vec_user_w = {vector_page_pointer_q, vec_num_i,
        2'b00};

    // Two-flop synchroniser on the mode pin.
    always @(posedge clk_i) begin
        pin_s1_q <= rom_disable_mode_pin_i;
        pin_s2_q <= pin_s1_q;
        rst_q <= rst_i;
    end

    // Mode status register with hardware reset, soft reset and writes.
    always @(posedge clk_i) begin
        if (rst_i) begin
            vector_page_pointer_q <= `VRM_PTR_RST;
            rom_disable_mode_q <= 1'b0;
            ram_overlay_q <= 1'b0;
            address_visibility_q <= 1'b0;
            upper_ram_data_map_q <= 1'b0;
            clock_output_off_q <= 1'b0;
            saturate_multiply_q <= 1'b0;
            saturate_store_q <= 1'b0;
        end else if (processor_mode_status_we_w) begin
            vector_page_pointer_q <=
                reg_wdata_i[`VRM_PTR_HI:`VRM_PTR_LO];
            rom_disable_mode_q <= reg_wdata_i[`VRM_BIT_ROM];
            ram_overlay_q <= reg_wdata_i[`VRM_BIT_RAM_OVERLAY];
            address_visibility_q <= reg_wdata_i[`VRM_BIT_ADDRESS_VISIBILITY];
            upper_ram_data_map_q <= reg_wdata_i[`VRM_BIT_UMAP];
            clock_output_off_q <= reg_wdata_i[`VRM_BIT_CKOFF];
            saturate_multiply_q <= reg_wdata_i[`VRM_BIT_SATURATE_MULTIPLY];
            saturate_store_q <= reg_wdata_i[`VRM_BIT_SST];
        end else if (rst_release_w) begin
            // Sample the pin once as reset releases.
            rom_disable_mode_q <= pin_s2_q;
        end else if (soft_reset_i) begin
            // Pointer and ROM disable bit are kept.
            ram_overlay_q <= 1'b0;
            address_visibility_q <= 1'b0;
            upper_ram_data_map_q <= 1'b0;
            clock_output_off_q <= 1'b0;
            saturate_multiply_q <= 1'b0;
            saturate_store_q <= 1'b0;
        end
    end

    // Register read port, data valid the cycle after the strobe.
    always @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_re_i) begin
            case (reg_addr_i)
                `VRM_OFS_PROCESSOR_MODE_STATUS: reg_rdata_o <= processor_mode_status_w;
                `VRM_OFS_STATUS: reg_rdata_o <= status_w;
                default: reg_rdata_o <= 16'h0000;
            endcase
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // Vector fetch: the pointer is captured when the request is taken.
    always @(posedge clk_i) begin
        if (rst_i) begin
            vec_load_o <= 1'b0;
            vec_addr_o <= 16'h0000;
        end else if (rst_release_w) begin
            // Reset vector fetched from the all-ones page.
            vec_load_o <= 1'b1;
            vec_addr_o <= vec_reset_w;
        end else if (vec_req_i) begin
            vec_load_o <= 1'b1;
            vec_addr_o <= vec_user_w;
        end else begin
            vec_load_o <= 1'b0;
        end
    end

    // External address pins follow the program address only when visible.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ext_addr_o <= 16'h0000;
        end else if (ext_access_i) begin
            ext_addr_o <= ext_addr_i;
        end else if (address_visibility_q) begin
            ext_addr_o <= prog_addr_i;
        end else begin
            ext_addr_o <= ext_addr_o;
        end
    end

    // Address decode of program and data space.
    vrm_map u_map (
        .rom_disable_mode_i(rom_disable_mode_q),
        .ram_overlay_i(ram_overlay_q),
        .upper_ram_data_map_i(upper_ram_data_map_q),
        .prog_addr_i(prog_addr_i),
        .data_addr_i(data_addr_i),
        .prog_rom_sel_o(rom_sel_w),
        .prog_ram_sel_o(ram_sel_w),
        .data_ram_sel_o(dram_sel_w),
        .data_ram_blk_o(dram_blk_w),
        .prog_ext_o(prog_ext_w)
    );

    // Registered memory selects.
    always @(posedge clk_i) begin
        if (rst_i) begin
            prog_rom_sel_o <= 1'b0;
            prog_ram_sel_o <= 1'b0;
            data_ram_sel_o <= 1'b0;
            data_ram_blk_o <= 3'h0;
        end else begin
            prog_rom_sel_o <= rom_sel_w;
            prog_ram_sel_o <= ram_sel_w;
            data_ram_sel_o <= dram_sel_w;
            data_ram_blk_o <= dram_blk_w;
        end
    end

    // Divider for the clock output pin.
    vrm_clkdiv #(
        .DIV(CLK_DIV),
        .CW(8)
    ) u_clkdiv (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(clk_tick_w)
    );

    // Phase flips on every divider tick.
    always @(posedge clk_i) begin
        if (rst_i) begin
            clk_phase_q <= 1'b0;
        end else if (clk_tick_w) begin
            clk_phase_q <= !clk_phase_q;
        end
    end

    // Pin follows the phase one cycle later unless held high.
    always @(posedge clk_i) begin
        if (rst_i) begin
            clock_output_pin_o <= 1'b0;
        end else if (clock_output_off_q) begin
            clock_output_pin_o <= 1'b1;
        end else begin
            clock_output_pin_o <= clk_phase_q;
        end
    end

    // Saturation of the product and of the shifted store value.
    assign sat_mul_en_w = saturate_multiply_q && overflow_mode_i &&
        fractional_mode_i;
    assign st_pos_ovf_w = !store_shifted_i[39] &&
        (store_shifted_i[38:15] != 24'h000000);
    assign st_neg_ovf_w = store_shifted_i[39] &&
        (store_shifted_i[38:15] != 24'hffffff);

    always @(posedge clk_i) begin
        if (rst_i) begin
            mul_prod_o <= 32'h00000000;
        end else if (sat_mul_en_w && mul_prod_i == `VRM_FRAC_OVF) begin
            mul_prod_o <= `VRM_MUL_MAX;
        end else begin
            mul_prod_o <= mul_prod_i;
        end
    end

    // Store saturation is applied to the already shifted value.
    always @(posedge clk_i) begin
        if (rst_i) begin
            store_data_o <= 16'h0000;
        end else if (saturate_store_q && st_pos_ovf_w) begin
            store_data_o <= `VRM_ST_MAX;
        end else if (saturate_store_q && st_neg_ovf_w) begin
            store_data_o <= `VRM_ST_MIN;
        end else begin
            store_data_o <= store_shifted_i[15:0];
        end
    end

    // Mode register mirror for the core.
    always @(posedge clk_i) begin
        if (rst_i) begin
            processor_mode_status_o <= processor_mode_status_rst_w;
        end else begin
            processor_mode_status_o <= processor_mode_status_w;
        end
    end
endmodule // vrm_top

// [verif/vrm_top_chk.sv]
// Checker for the mode status register and vector relocation block.
// Assumes it is bound to vrm_top and sees only that module's ports.
module vrm_top_chk (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Vector fetch
    input wire vec_req_i,
    input wire [4:0] vec_num_i,
    input wire vec_load_o,
    input wire [15:0] vec_addr_o,
    // Addresses and selects
    input wire [15:0] prog_addr_i,
    input wire ext_access_i,
    input wire [15:0] ext_addr_o,
    input wire [15:0] data_addr_i,
    input wire prog_rom_sel_o,
    input wire prog_ram_sel_o,
    input wire data_ram_sel_o,
    input wire [2:0] data_ram_blk_o,
    // Clock pin, saturation and mode copy
    input wire clock_output_pin_o,
    input wire overflow_mode_i,
    input wire fractional_mode_i,
    input wire [31:0] mul_prod_i,
    input wire [31:0] mul_prod_o,
    input wire [15:0] processor_mode_status_o
);
    wire [15:0] pm = processor_mode_status_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    rst_vec_a: assert property ($fell(rst_i) |=> vec_load_o
        && vec_addr_o == 16'hff80) else $error("reset vector wrong");
    vec_low_a: assert property (vec_req_i && !$past(rst_i) |=>
        vec_load_o && vec_addr_o[6:0] == {$past(vec_num_i), 2'b00})
        else $error("vector slot address wrong");
    pc_load_a: assert property (vec_load_o |-> $past(vec_req_i)
        || $past(rst_i, 2)) else $error("vector load without cause");
    vis_hold_a: assert property (!ext_access_i ##1 !pm[4] |->
        ext_addr_o == $past(ext_addr_o)) else $error("address pins moved");
    vis_drive_a: assert property (!ext_access_i ##1 pm[4] |->
        ext_addr_o == $past(prog_addr_i)) else $error("address not shown");
    rom_sel_a: assert property (!$past(rst_i) |-> prog_rom_sel_o ==
        (!pm[6] && $past(prog_addr_i) >= 16'hc000))
        else $error("rom select wrong");
    ram_overlay_sel_a: assert property (!$past(rst_i) |->
        prog_ram_sel_o == (pm[5] && $past(prog_addr_i) >= 16'h0080
        && $past(prog_addr_i) <= 16'h7fff)) else $error("overlay wrong");
    dram_sel_a: assert property (!$past(rst_i) |->
        data_ram_sel_o == (($past(data_addr_i) >= 16'h0080
        && $past(data_addr_i) <= 16'h7fff) || (pm[3] && $past(data_addr_i)
        >= 16'h8000))) else $error("data ram select wrong");
    dram_blk_a: assert property (!$past(rst_i) |->
        data_ram_blk_o == $past(data_addr_i[15:13]))
        else $error("data ram block wrong");
    clk_off_a: assert property (pm[2] |-> clock_output_pin_o)
        else $error("clock pin not held high");
    sat_mul_a: assert property (!$past(rst_i) |-> mul_prod_o ==
        ((pm[1] && $past(overflow_mode_i && fractional_mode_i)
        && $past(mul_prod_i) == 32'h40000000) ? 32'h7fffffff
        : $past(mul_prod_i))) else $error("product saturation wrong");
endmodule // vrm_top_chk

bind vrm_top vrm_top_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .vec_req_i(vec_req_i), .vec_num_i(vec_num_i), .vec_load_o(vec_load_o),
    .vec_addr_o(vec_addr_o), .prog_addr_i(prog_addr_i),
    .ext_access_i(ext_access_i), .ext_addr_o(ext_addr_o),
    .data_addr_i(data_addr_i), .prog_rom_sel_o(prog_rom_sel_o),
    .prog_ram_sel_o(prog_ram_sel_o), .data_ram_sel_o(data_ram_sel_o),
    .data_ram_blk_o(data_ram_blk_o), .clock_output_pin_o(clock_output_pin_o),
    .overflow_mode_i(overflow_mode_i), .fractional_mode_i(fractional_mode_i),
    .mul_prod_i(mul_prod_i), .mul_prod_o(mul_prod_o),
    .processor_mode_status_o(processor_mode_status_o));

// [verif/vector_relocation_mode_reg_tb_top.sv]
// Self-checking bench for the mode status register and vector relocation.
// Assumes vrm_top with its checker bound; the bench drives every input.
module vector_relocation_mode_reg_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, reg_we_i = 0, reg_re_i = 0, soft_reset_i = 0;
    logic rom_disable_mode_pin_i = 1, overflow_mode_i = 0, vec_req_i = 0;
    logic fractional_mode_i = 0, ext_access_i = 0, seen;
    logic [7:0] reg_addr_i = 8'h00;
    logic [4:0] vec_num_i = 5'h00;
    logic [15:0] reg_wdata_i = 16'h0000, prog_addr_i = 16'h0000;
    logic [15:0] ext_addr_i = 16'h0000, data_addr_i = 16'h0000;
    logic [31:0] mul_prod_i = 32'h0;
    logic [39:0] store_shifted_i = 40'h0;
    wire [15:0] reg_rdata_o, vec_addr_o, ext_addr_o, store_data_o;
    wire [15:0] processor_mode_status_o;
    wire vec_load_o, prog_rom_sel_o, prog_ram_sel_o, data_ram_sel_o;
    wire clock_output_pin_o;
    wire [2:0] data_ram_blk_o;
    wire [31:0] mul_prod_o;
    int n_errors = 0, n_tests = 0, i, m;
    logic [15:0] ad [8] = '{16'h0000, 16'h007f, 16'h0080, 16'h7fff,
        16'h8000, 16'hbfff, 16'hc000, 16'hffff};
    logic [15:0] md [3] = '{16'hff30, 16'hff48, 16'hff80};
    logic [39:0] sv [3] = '{40'h0000018000, 40'hfffffe0000, 40'h0000001234};
    logic [15:0] se [3] = '{16'h7fff, 16'h8000, 16'h1234};

    always #5 clk_i = ~clk_i;

    vrm_top #(.CLK_DIV(2)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
        .rom_disable_mode_pin_i(rom_disable_mode_pin_i),
        .soft_reset_i(soft_reset_i), .overflow_mode_i(overflow_mode_i),
        .fractional_mode_i(fractional_mode_i), .vec_req_i(vec_req_i),
        .vec_num_i(vec_num_i), .vec_load_o(vec_load_o),
        .vec_addr_o(vec_addr_o), .prog_addr_i(prog_addr_i),
        .ext_access_i(ext_access_i), .ext_addr_i(ext_addr_i),
        .ext_addr_o(ext_addr_o), .data_addr_i(data_addr_i),
        .prog_rom_sel_o(prog_rom_sel_o), .prog_ram_sel_o(prog_ram_sel_o),
        .data_ram_sel_o(data_ram_sel_o), .data_ram_blk_o(data_ram_blk_o),
        .clock_output_pin_o(clock_output_pin_o), .mul_prod_i(mul_prod_i),
        .mul_prod_o(mul_prod_o), .store_shifted_i(store_shifted_i),
        .store_data_o(store_data_o),
        .processor_mode_status_o(processor_mode_status_o));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        @(posedge clk_i);
        chk({16'h0, reg_rdata_o}, {16'h0, exp});
    endtask

    task automatic vec_chk(input logic [4:0] n, input logic [15:0] exp);
        @(posedge clk_i);
        vec_req_i <= 1'b1;
        vec_num_i <= n;
        @(posedge clk_i);
        vec_req_i <= 1'b0;
        @(posedge clk_i);
        chk({15'h0, vec_load_o, vec_addr_o}, {16'h1, exp});
    endtask

    task automatic do_reset(input logic pin);
        rst_i <= 1'b1;
        rom_disable_mode_pin_i <= pin;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk({15'h0, vec_load_o, vec_addr_o}, 32'h1ff80);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #200000;
        n_errors++;
        end_of_test();
    end

    initial begin
        do_reset(1'b1);
        rd_chk(8'h00, 16'hffc0);
        rd_chk(8'h05, 16'h0000);
        wr(8'h01, 16'h1234);
        rd_chk(8'h00, 16'hffc0);
        $display("reset test done");
        wr(8'h00, 16'h0100);
        for (i = 0; i < 32; i += 7)
            vec_chk(i[4:0], {9'h002, i[4:0], 2'b00});
        @(posedge clk_i);
        reg_we_i <= 1'b1;
        reg_wdata_i <= 16'h3f80;
        vec_req_i <= 1'b1;
        vec_num_i <= 5'h01;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
        vec_req_i <= 1'b0;
        @(posedge clk_i);
        chk({16'h0, vec_addr_o}, 32'h0104);
        vec_chk(5'h01, 16'h3f84);
        $display("vector test done");
        wr(8'h00, 16'h3fff);
        @(posedge clk_i);
        soft_reset_i <= 1'b1;
        rom_disable_mode_pin_i <= 1'b0;
        @(posedge clk_i);
        soft_reset_i <= 1'b0;
        rd_chk(8'h00, 16'h3fc0);
        wr(8'h00, 16'h3f80);
        rd_chk(8'h00, 16'h3f80);
        $display("soft reset test done");
        for (m = 0; m < 3; m++) begin
            wr(8'h00, md[m]);
            for (i = 0; i < 16; i++) begin
                @(posedge clk_i);
                prog_addr_i <= ad[i % 8];
                data_addr_i <= ad[7 - i % 8];
                ext_access_i <= (i == 5);
                ext_addr_i <= ad[i % 8] ^ 16'h5a5a;
            end
        end
        $display("map test done");
        // With a divide of 2 the pin must differ from its value 2 cycles ago.
        seen = 1'b0;
        for (i = 0; i < 12; i++) begin
            @(posedge clk_i);
            if (i > 1 && clock_output_pin_o === m[1]) seen = 1'b1;
            m = {30'h0, m[0], clock_output_pin_o};
        end
        chk({31'h0, seen}, 32'h0);
        wr(8'h00, 16'h0004);
        repeat (2) @(posedge clk_i);
        for (i = 0; i < 8; i++) begin
            @(posedge clk_i);
            chk({31'h0, clock_output_pin_o}, 32'h1);
        end
        $display("clock pin test done");
        wr(8'h00, 16'h0003);
        @(posedge clk_i);
        overflow_mode_i <= 1'b1;
        fractional_mode_i <= 1'b1;
        mul_prod_i <= 32'h40000000;
        repeat (2) @(posedge clk_i);
        chk(mul_prod_o, 32'h7fffffff);
        for (i = 0; i < 3; i++) begin
            store_shifted_i <= sv[i];
            repeat (2) @(posedge clk_i);
            chk({16'h0, store_data_o}, {16'h0, se[i]});
        end
        wr(8'h00, 16'h0000);
        store_shifted_i <= sv[0];
        repeat (2) @(posedge clk_i);
        chk({16'h0, store_data_o}, 32'h8000);
        chk(mul_prod_o, 32'h40000000);
        $display("saturation test done");
        do_reset(1'b0);
        rd_chk(8'h00, 16'hff80);
        $display("second reset test done");
        end_of_test();
    end
endmodule // vector_relocation_mode_reg_tb_top
